// *** core/eii_pkg.sv ***
// constants for the external interrupt input front end
package eii_pkg;
   localparam int EII_NUM_MASK   = 5;   // maskable request inputs 0..4
   localparam int EII_NUM_DMA    = 2;   // level-only requests 5 and 6
   localparam int EII_NUM_REQ    = 7;
   localparam int EII_SYNC_DEPTH = 2;
   localparam int EII_IDX_ZERO   = 0;
   localparam int EII_IDX_ONE    = 1;
   localparam int EII_IDX_TWO    = 2;
   localparam int EII_IDX_THREE  = 3;
   localparam int EII_IDX_FIVE   = 5;
   localparam int EII_IDX_SIX    = 6;
   localparam logic [2:0] EII_SRC_NMI  = 3'h7;
   localparam logic [2:0] EII_SRC_NONE = 3'h0;
   localparam logic [6:0] EII_PEND_RST = 7'h00;
   typedef enum logic [1:0] {
      EII_ST_IDLE,
      EII_ST_SLAVE_REQ,
      EII_ST_SLAVE_SEL
   } eii_slave_st_t;
endpackage : eii_pkg

// *** core/eii_sync.sv ***
// two-stage synchroniser bank for pin inputs
`timescale 1ns/10ps
`default_nettype none
module eii_sync #(
   parameter int W = 1
) (
   input  wire logic         i_core_clk,
   input  wire logic         i_sys_rst,
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
   } eii_sync_st_t;

   eii_sync_st_t st_r;
   eii_sync_st_t st_nxt;

   // meta feeds only the second stage
   always_comb begin
      st_nxt      = st_r;
      st_nxt.meta = i_async;
      st_nxt.sync = st_r.meta;
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_sync = st_r.sync;
endmodule : eii_sync
`default_nettype wire

// *** core/eii_front.sv ***
// pin front end: nmi, maskable requests, cascade acks, slave link, gpio
//
// Behaviour
// - rising nmi edge raises top-priority request that no mask blocks
// - request four active high; enabled line raises its own vector
// - each maskable input configurable edge or level triggered
// - inputs zero to three behave as input four, except that cascade or slave mode takes over pins one to three
// - cascade mode: pins three and two become acks one and zero
// - slave mode drives slave request output toward master
// - dma pins unused: serve as requests five and six
// - requests five and six level only, pending while high
// - gpio mode turns interrupt pins into general purpose io
// - maskable requests raise the request output only while enable flag set
`timescale 1ns/10ps
`default_nettype none
module eii_front
   import eii_pkg::*;
(
   input  wire logic                   i_core_clk,
   input  wire logic                   i_sys_rst,
   input  wire logic                   i_nmi_pin,
   input  wire logic [EII_NUM_MASK-1:0] i_ext_request_pin,
   input  wire logic [EII_NUM_DMA-1:0]  i_dma_pin,
   input  wire logic [EII_NUM_REQ-1:0]  i_level_mode,
   input  wire logic [EII_NUM_REQ-1:0]  i_req_enable,
   input  wire logic                   i_int_enable_flag,
   input  wire logic                   i_cascade_mode,
   input  wire logic                   i_slave_mode,
   input  wire logic                   i_dma_unused,
   input  wire logic [EII_NUM_REQ-1:0]  i_gpio_mode,
   input  wire logic [EII_NUM_REQ-1:0]  i_gpio_dir_out,
   input  wire logic [EII_NUM_REQ-1:0]  i_gpio_out,
   input  wire logic [EII_NUM_REQ-1:0]  i_ack,
   input  wire logic                   i_nmi_ack,
   input  wire logic [1:0]             i_cascade_ack,
   output logic                        o_nmi_pending,
   output logic      [EII_NUM_REQ-1:0] o_pending,
   output logic                        o_int_request,
   output logic      [2:0]             o_int_source,
   output logic                        o_slave_select,
   output logic                        o_type_valid,
   output logic      [EII_NUM_REQ-1:0] o_gpio_in,
   output logic      [EII_NUM_REQ-1:0] o_pin_out,
   output logic      [EII_NUM_REQ-1:0] o_pin_oe_n,
   output logic                        o_clock_out_primary
);
   localparam int SW = 1 + EII_NUM_REQ;

   typedef struct packed {
      logic                   nmi_prev;
      logic                   nmi_pend;
      logic [EII_NUM_REQ-1:0] prev;
      logic [EII_NUM_REQ-1:0] pend;
      eii_slave_st_t          slave;
      logic [EII_NUM_REQ-1:0] pin_out;
      logic [EII_NUM_REQ-1:0] pin_oe_n;
      logic [2:0]             src;
      logic                   req;
   } eii_front_st_t;

   eii_front_st_t          st_r;
   eii_front_st_t          st_nxt;
   logic [SW-1:0]          sync_out;
   logic                   nmi_s;
   logic [EII_NUM_REQ-1:0] req_s;
   logic [EII_NUM_REQ-1:0] trig;
   logic [EII_NUM_REQ-1:0] masked;
   logic                   slave_sel_s;

   eii_sync #(.W(SW)) u_sync (
      .i_core_clk (i_core_clk),
      .i_sys_rst  (i_sys_rst),
      .i_async    ({i_dma_pin, i_ext_request_pin, i_nmi_pin}),
      .o_sync     (sync_out)
   );

   assign nmi_s       = sync_out[0];
   assign req_s       = sync_out[SW-1:1];
   assign slave_sel_s = req_s[EII_IDX_ONE];

   genvar g;
   generate
      for (g = 0; g < EII_NUM_REQ; g++) begin : g_req
         if (g < EII_NUM_MASK) begin : g_mask
            // edge or level per input; level assumes source holds to ack
            assign trig[g] = i_level_mode[g] ? req_s[g]
                                             : req_s[g] & ~st_r.prev[g];
         end else begin : g_dma
            assign trig[g] = req_s[g] & i_dma_unused;
         end
      end
   endgenerate

   // a pin in gpio or cascade ack role never requests
   always_comb begin
      masked = trig & ~i_gpio_mode;
      if (i_cascade_mode) begin
         masked[EII_IDX_TWO]   = 1'b0;
         masked[EII_IDX_THREE] = 1'b0;
      end
      if (i_slave_mode) begin
         masked[EII_IDX_ONE]   = 1'b0;
         masked[EII_IDX_THREE] = 1'b0;
      end
   end

   always_comb begin
      st_nxt          = st_r;
      st_nxt.nmi_prev = nmi_s;
      st_nxt.prev     = req_s;
      // set beats ack in the same cycle
      if (i_nmi_ack) begin
         st_nxt.nmi_pend = 1'b0;
      end
      if (nmi_s && !st_r.nmi_prev) begin
         st_nxt.nmi_pend = 1'b1;
      end
      for (int i = 0; i < EII_NUM_REQ; i++) begin
         if (i_ack[i]) begin
            st_nxt.pend[i] = 1'b0;
         end
         if (i >= EII_NUM_MASK && !req_s[i]) begin
            st_nxt.pend[i] = 1'b0;
         end
         if (masked[i] && i_req_enable[i]) begin
            st_nxt.pend[i] = 1'b1;
         end
      end
      st_nxt.src = EII_SRC_NONE;
      st_nxt.req = 1'b0;
      if (st_nxt.nmi_pend) begin
         st_nxt.src = EII_SRC_NMI;
         st_nxt.req = 1'b1;
      end else if (i_int_enable_flag && (st_nxt.pend != EII_PEND_RST)) begin
         st_nxt.req = 1'b1;
         for (int i = EII_NUM_REQ - 1; i >= 0; i--) begin
            if (st_nxt.pend[i]) begin
               st_nxt.src = 3'(i);
            end
         end
      end
      // slave link: request out on pin three, select in on pin one
      case (st_r.slave)
         EII_ST_IDLE: begin
            if (i_slave_mode && st_nxt.req && !st_nxt.nmi_pend) begin
               st_nxt.slave = EII_ST_SLAVE_REQ;
            end
         end
         EII_ST_SLAVE_REQ: begin
            if (!i_slave_mode) begin
               st_nxt.slave = EII_ST_IDLE;
            end else if (slave_sel_s && req_s[EII_IDX_ZERO]) begin
               st_nxt.slave = EII_ST_SLAVE_SEL;
            end
         end
         EII_ST_SLAVE_SEL: begin
            if (!slave_sel_s || !i_slave_mode) begin
               st_nxt.slave = EII_ST_IDLE;
            end
         end
         default: st_nxt.slave = EII_ST_IDLE;
      endcase
      // pin drivers, oe low while driving
      st_nxt.pin_out  = i_gpio_out;
      st_nxt.pin_oe_n = ~(i_gpio_mode & i_gpio_dir_out);
      if (i_cascade_mode) begin
         st_nxt.pin_out[EII_IDX_THREE]  = i_cascade_ack[EII_IDX_ONE];
         st_nxt.pin_out[EII_IDX_TWO]    = i_cascade_ack[EII_IDX_ZERO];
         st_nxt.pin_oe_n[EII_IDX_THREE] = 1'b0;
         st_nxt.pin_oe_n[EII_IDX_TWO]   = 1'b0;
      end
      if (i_slave_mode) begin
         st_nxt.pin_out[EII_IDX_THREE]  = st_nxt.slave == EII_ST_SLAVE_REQ;
         st_nxt.pin_oe_n[EII_IDX_THREE] = 1'b0;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         st_r <= '{slave: EII_ST_IDLE, pin_oe_n: '1, default: '0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_nmi_pending       = st_r.nmi_pend;
   assign o_pending           = st_r.pend;
   assign o_int_request       = st_r.req;
   assign o_int_source        = st_r.src;
   assign o_slave_select      = st_r.slave == EII_ST_SLAVE_SEL;
   assign o_type_valid        = st_r.slave == EII_ST_SLAVE_SEL;
   assign o_gpio_in           = st_r.prev;
   assign o_pin_out           = st_r.pin_out;
   assign o_pin_oe_n          = st_r.pin_oe_n;
   // internal clock seen directly as the clock output
   assign o_clock_out_primary = i_core_clk;
endmodule : eii_front
`default_nettype wire

// *** verification/eii_front_asserts.sv ***
// checker for the pin front end
`timescale 1ns/10ps
`default_nettype none
module eii_front_asserts
   import eii_pkg::*;
(
   input wire logic                    i_core_clk,
   input wire logic                    i_sys_rst,
   input wire logic                    i_nmi_pin,
   input wire logic [EII_NUM_MASK-1:0] i_ext_request_pin,
   input wire logic [EII_NUM_DMA-1:0]  i_dma_pin,
   input wire logic [EII_NUM_REQ-1:0]  i_req_enable,
   input wire logic                    i_int_enable_flag,
   input wire logic                    i_cascade_mode,
   input wire logic                    i_dma_unused,
   input wire logic [EII_NUM_REQ-1:0]  i_gpio_mode,
   input wire logic [1:0]              i_cascade_ack,
   input wire logic                    o_nmi_pending,
   input wire logic [EII_NUM_REQ-1:0]  o_pending,
   input wire logic                    o_int_request,
   input wire logic [EII_NUM_REQ-1:0]  o_pin_out,
   input wire logic [EII_NUM_REQ-1:0]  o_pin_oe_n
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);
   a_nmi_seen: assert property ($rose(i_nmi_pin) |-> ##[2:4] o_nmi_pending)
      else $error("nmi edge not taken");
   a_if_mask: assert property ((!i_int_enable_flag)[*2] ##0 !o_nmi_pending
      |-> !o_int_request) else $error("request while flag clear");
   a_line_enable: assert property ($rose(o_pending[4]) |->
      $past(i_req_enable[4])) else $error("disabled line pending");
   a_pend_cause: assert property ($rose(o_pending[2]) |->
      $past(i_ext_request_pin[2], 3)) else $error("pending w/o pin");
   a_gpio_gate: assert property ($rose(o_pending[0]) |->
      !$past(i_gpio_mode[0])) else $error("gpio pin pending");
   a_dma_gate: assert property ($rose(o_pending[5]) |->
      $past(i_dma_unused)) else $error("dma pin pending");
   a_dma_level: assert property ((!i_dma_pin[1])[*5] |-> !o_pending[6])
      else $error("level request stuck");
   a_cascade_ack: assert property ($past(i_cascade_mode) |->
      o_pin_oe_n[3:2] == 2'h0 && o_pin_out[3:2] == $past(i_cascade_ack))
      else $error("cascade ack pins wrong");
endmodule : eii_front_asserts
bind eii_front eii_front_asserts i_chk (.*);
`default_nettype wire

// *** verification/eii_src_model.sv ***
// interrupt sources and master select on the far side
`timescale 1ns/10ps
`default_nettype none
module eii_src_model (
   input  wire logic       i_core_clk,
   input  wire logic [6:0] i_fire,
   input  wire logic       i_nmi_fire,
   input  wire logic [6:0] i_ack,
   input  wire logic       i_sel,
   output logic            o_nmi_pin,
   output logic      [4:0] o_ext_pin,
   output logic      [1:0] o_dma_pin
);
   logic [4:0] held_r = 5'h00;
   logic [1:0] nmi_r  = 2'h0;
   logic [1:0] dma_r  = 2'h0;
   always_ff @(posedge i_core_clk) begin
      held_r <= (held_r | i_fire[4:0]) & ~i_ack[4:0];
      nmi_r  <= {nmi_r[0], i_nmi_fire};
      dma_r  <= i_fire[6:5];
   end
   // two cycles high covers two output clock periods
   assign o_nmi_pin = |nmi_r;
   assign o_ext_pin = held_r | {3'h0, i_sel & held_r[0], 1'h0};
   assign o_dma_pin = dma_r;
endmodule : eii_src_model
`default_nettype wire

// *** verification/tb_eii_front.sv ***
// self-checking bench for the pin front end
`timescale 1ns/10ps
`default_nettype none
module tb_eii_front;
   import eii_pkg::*;
   logic i_core_clk = 1'h0, i_sys_rst = 1'h1, i_int_enable_flag = 1'h1;
   logic i_cascade_mode = 1'h0, i_slave_mode = 1'h0, i_dma_unused = 1'h1;
   logic i_nmi_ack = 1'h0, fire_nmi = 1'h0, sel = 1'h0, i_nmi_pin;
   logic [6:0] i_level_mode = '0, i_req_enable = 7'h7f, i_gpio_mode = '0;
   logic [6:0] i_gpio_dir_out = '0, i_gpio_out = '0, i_ack = '0, fire = '0;
   logic [4:0] i_ext_request_pin;
   logic [1:0] i_dma_pin, i_cascade_ack = 2'h0;
   logic o_nmi_pending, o_int_request, o_slave_select, o_type_valid;
   logic o_clock_out_primary;
   logic [6:0] o_pending, o_gpio_in, o_pin_out, o_pin_oe_n;
   logic [2:0] o_int_source;
   logic [7:0] lvl_e;
   int failures = 0, n_compared = 0;
   localparam logic [9:0] ROWS [7] = '{10'h008, 10'h011, 10'h022, 10'h043,
      10'h084, 10'h105, 10'h206};
   eii_front i_dut (.*);
   eii_src_model i_src (.i_core_clk(i_core_clk), .i_fire(fire),
      .i_nmi_fire(fire_nmi), .i_ack(i_ack), .i_sel(sel),
      .o_nmi_pin(i_nmi_pin), .o_ext_pin(i_ext_request_pin),
      .o_dma_pin(i_dma_pin));
   task automatic cyc(input int n);
      repeat (n) @(posedge i_core_clk);
      #1;
   endtask : cyc
   task automatic chk(input string nm, input logic [7:0] e, g);
      n_compared++;
      if (e !== g) begin
         failures++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic ackp(input logic [6:0] v);
      i_ack <= v;
      cyc(1);
      i_ack <= '0;
      cyc(4);
   endtask : ackp
   task automatic results;
      if (failures == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : results
   initial forever #2 i_core_clk = ~i_core_clk;
   initial begin
      repeat (2000) @(posedge i_core_clk);
      failures++;
      results();
   end
   initial begin
      repeat (5) @(posedge i_core_clk);
      i_sys_rst <= 1'h0;
      cyc(1);
      chk("oe_n", 8'h7f, {1'h0, o_pin_oe_n});
      chk("pend", 8'h00, {1'h0, o_pending});
      chk("clko", 8'h01, {7'h0, o_clock_out_primary});
      for (int lv = 0; lv < 2; lv++) begin
         i_level_mode <= {7{lv[0]}};
         for (int r = 0; r < 7; r++) begin
            fire <= ROWS[r][9:3];
            cyc(5);
            chk("pend", {1'h0, ROWS[r][9:3]}, {1'h0, o_pending});
            chk("src", {5'h0, ROWS[r][2:0]}, {5'h0, o_int_source});
            chk("irq", 8'h01, {7'h0, o_int_request});
            fire <= '0;
            ackp(ROWS[r][9:3]);
            // level-mode maskable lines re-arm from the synchroniser lag, edge and dma lines do not
            lvl_e = (lv == 1 && r < EII_NUM_MASK) ? {1'h0, ROWS[r][9:3]}
                                                   : 8'h00;
            chk("lvl", lvl_e, {1'h0, o_pending});
            ackp(ROWS[r][9:3]);
            chk("clr", 8'h00, {1'h0, o_pending});
         end
      end
      i_int_enable_flag <= 1'h0;
      fire <= 7'h10;
      fire_nmi <= 1'h1;
      cyc(1);
      fire_nmi <= 1'h0;
      cyc(5);
      chk("irqn", 8'h01, {7'h0, o_int_request});
      chk("nmi", 8'h01, {7'h0, o_nmi_pending});
      chk("nsrc", {5'h0, EII_SRC_NMI}, {5'h0, o_int_source});
      i_nmi_ack <= 1'h1;
      fire <= '0;
      cyc(1);
      i_nmi_ack <= 1'h0;
      cyc(1);
      chk("irqm", 8'h00, {7'h0, o_int_request});
      chk("keep", 8'h10, {1'h0, o_pending});
      i_int_enable_flag <= 1'h1;
      cyc(1);
      chk("irqe", 8'h01, {7'h0, o_int_request});
      ackp(7'h10);
      ackp(7'h10);
      // disabled line, gpio pin and unused-off dma pin must stay quiet
      i_req_enable <= 7'h7b;
      i_gpio_mode <= 7'h41;
      i_gpio_dir_out <= 7'h40;
      i_gpio_out <= 7'h40;
      i_dma_unused <= 1'h0;
      fire <= 7'h25;
      cyc(5);
      chk("gate", 8'h00, {1'h0, o_pending});
      chk("gpio", 8'h01, {7'h0, o_gpio_in[0]});
      chk("gpoe", 8'h3f, {1'h0, o_pin_oe_n});
      chk("gpo", 8'h40, {1'h0, o_pin_out});
      fire <= '0;
      ackp(7'h05);
      i_gpio_mode <= '0;
      i_cascade_mode <= 1'h1;
      i_cascade_ack <= 2'h1;
      cyc(2);
      chk("cack", 8'h01, {6'h0, o_pin_out[3:2]});
      chk("coe", 8'h00, {6'h0, o_pin_oe_n[3:2]});
      i_cascade_mode <= 1'h0;
      i_slave_mode <= 1'h1;
      fire <= 7'h01;
      cyc(5);
      chk("sreq", 8'h01, {7'h0, o_pin_out[3]});
      sel <= 1'h1;
      cyc(5);
      chk("ssel", 8'h01, {7'h0, o_slave_select});
      chk("tval", 8'h01, {7'h0, o_type_valid});
      chk("sdrop", 8'h00, {7'h0, o_pin_out[3]});
      // mid-run reset must drop the slave handshake and all pending
      i_sys_rst <= 1'h1;
      i_slave_mode <= 1'h0;
      sel <= 1'h0;
      fire <= '0;
      i_ack <= 7'h7f;
      cyc(3);
      i_sys_rst <= 1'h0;
      i_ack <= '0;
      cyc(1);
      chk("rpend", 8'h00, {1'h0, o_pending});
      chk("rsel", 8'h00, {7'h0, o_slave_select});
      chk("roe", 8'h7f, {1'h0, o_pin_oe_n});
      results();
   end
endmodule : tb_eii_front
`default_nettype wire
